// >>> rtl/idc_ctrl.sv
// Idle controller: domain clock gating, PLL and oscillator power-down, wake sequencing
`timescale 1ns/100ps
`include "idc_map.svh"
module idc_ctrl #(
	parameter int OSC_STAB_CYC = `IDC_OSC_STAB_CYC
) (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	// Link to software end
	idc_if.dev BUS,
	// Activity of gated modules
	input wire logic I_DMA_BUSY,
	input wire logic [`IDC_PERIPHERAL_IDLE_MASK_W-1:0] I_PERIPHERAL_DOMAIN_IDLE_REQUEST_BUSY,
	// Wake pins
	input wire logic I_NMI,
	input wire logic [`IDC_INT_W-1:0] I_EXT_INT,
	// Domain clock enables
	output logic O_CPU_CLK_EN,
	output logic O_DMA_CLK_EN,
	output logic O_HPI_CLK_EN,
	output logic O_ICACHE_CLK_EN,
	output logic O_IPORT_CLK_EN,
	output logic [`IDC_PERIPHERAL_IDLE_MASK_W-1:0] O_PERIPHERAL_DOMAIN_IDLE_REQUEST_CLK_EN,
	output logic O_CLKGEN_CLK_EN,
	output logic O_MEMORY_INTERFACE_CLK_EN,
	// Power and status
	output logic O_REFRESH_EN,
	output logic O_PLL_PWRDN,
	output logic O_OSC_PWRDN,
	output logic O_CPU_IDLE
);
	import idc_pkg::*;

	idc_state_e state_q;
	logic [`IDC_ICR_W-1:0] icr_q;
	logic [`IDC_ICR_W-1:0] idle_status_latch_q;
	logic [`IDC_MASTER_PORT_IDLE_MASK_W-1:0] master_port_idle_mask_q;
	logic [`IDC_PERIPHERAL_IDLE_MASK_W-1:0] peripheral_idle_mask_q;
	logic [`IDC_PLL_W-1:0] pll_q;
	logic [`IDC_OSCILLATOR_WAKE_MASK_W-1:0] oscillator_wake_mask_q;
	logic [`IDC_INT_W-1:0] ier_q;
	idc_word_t rdata_q;
	logic [15:0] stab_cnt_q;
	logic osc_off_q;
	logic dma_off_q;
	logic [`IDC_PERIPHERAL_IDLE_MASK_W-1:0] peripheral_domain_idle_request_off_q;
	logic memory_interface_off_q;
	logic nmi_s1_q;
	logic nmi_s2_q;
	logic [`IDC_INT_W-1:0] int_s1_q;
	logic [`IDC_INT_W-1:0] int_s2_q;
	logic wake_ev;
	logic idle_now;
	logic memory_interface_req;
	logic [15:0] stab_last;

	// Pick a register by index, unmapped reads give zero
	function automatic idc_word_t reg_pick(input idc_idx_t idx);
		idc_word_t v;
		v = 16'h0000;
		if (idx == `IDC_IDX_ICR) begin
			v = {6'h00, icr_q};
		end else if (idx == `IDC_IDX_IDLE_STATUS_LATCH) begin
			v = {6'h00, idle_status_latch_q};
		end else if (idx == `IDC_IDX_MASTER_PORT_IDLE_MASK) begin
			v = {14'h0000, master_port_idle_mask_q};
		end else if (idx == `IDC_IDX_PERIPHERAL_IDLE_MASK) begin
			v = {2'h0, peripheral_idle_mask_q};
		end else if (idx == `IDC_IDX_PLL) begin
			v = {12'h000, pll_q};
		end else if (idx == `IDC_IDX_OSCILLATOR_WAKE_MASK) begin
			v = {11'h000, oscillator_wake_mask_q};
		end else if (idx == `IDC_IDX_IER) begin
			v = {12'h000, ier_q};
		end else if (idx == `IDC_IDX_STAT) begin
			v = {osc_off_q, memory_interface_off_q, dma_off_q, 11'h000, state_q};
		end
		return v;
	endfunction

	// Wake pins pass two flip-flops before use
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			nmi_s1_q <= 1'b0;
			nmi_s2_q <= 1'b0;
			int_s1_q <= '0;
			int_s2_q <= '0;
		end else begin
			nmi_s1_q <= I_NMI;
			nmi_s2_q <= nmi_s1_q;
			int_s1_q <= I_EXT_INT;
			int_s2_q <= int_s1_q;
		end
	end

	// Selected NMI, or selected and enabled external interrupt
	assign wake_ev = (nmi_s2_q & oscillator_wake_mask_q[`IDC_OSCILLATOR_WAKE_MASK_NMI])
		| (|(int_s2_q & oscillator_wake_mask_q[`IDC_OSCILLATOR_WAKE_MASK_W-1:`IDC_OSCILLATOR_WAKE_MASK_EXTERNAL_INTERRUPT_ZERO] & ier_q)); // RQ18
	assign idle_now = (state_q == IDC_IDLE);
	// Memory interface asked through control word or through peripheral mask
	assign memory_interface_req = idle_status_latch_q[`IDC_ICR_MEMORY_INTERFACE]
		| (idle_status_latch_q[`IDC_ICR_PERIPHERAL_DOMAIN_IDLE_REQUEST] & peripheral_idle_mask_q[`IDC_PERIPHERAL_IDLE_MASK_MEMORY_INTERFACE]); // RQ10
	assign stab_last = 16'(OSC_STAB_CYC - 1);

	// Register writes from the software end
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			icr_q <= '0;
			master_port_idle_mask_q <= '0;
			peripheral_idle_mask_q <= '0;
			pll_q <= `IDC_PLL_RESET;
			oscillator_wake_mask_q <= '0;
			ier_q <= '0;
		end else if (BUS.wr) begin
			if (BUS.addr == `IDC_IDX_ICR) begin
				icr_q <= BUS.wdata[`IDC_ICR_W-1:0];
			end else if (BUS.addr == `IDC_IDX_MASTER_PORT_IDLE_MASK) begin
				master_port_idle_mask_q <= BUS.wdata[`IDC_MASTER_PORT_IDLE_MASK_W-1:0];
			end else if (BUS.addr == `IDC_IDX_PERIPHERAL_IDLE_MASK) begin
				peripheral_idle_mask_q <= BUS.wdata[`IDC_PERIPHERAL_IDLE_MASK_W-1:0];
			end else if (BUS.addr == `IDC_IDX_PLL) begin
				pll_q <= BUS.wdata[`IDC_PLL_W-1:0];
			end else if (BUS.addr == `IDC_IDX_OSCILLATOR_WAKE_MASK) begin
				oscillator_wake_mask_q <= BUS.wdata[`IDC_OSCILLATOR_WAKE_MASK_W-1:0];
			end else if (BUS.addr == `IDC_IDX_IER) begin
				ier_q <= BUS.wdata[`IDC_INT_W-1:0];
			end
		end
	end

	// Read data stands in the cycle after the read strobe
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			rdata_q <= '0;
		end else if (BUS.rd) begin
			rdata_q <= reg_pick(BUS.addr);
		end else begin
			rdata_q <= '0;
		end
	end
	assign BUS.rdata = rdata_q;

	// Idle sequencer: latch, wait for wake, stabilise, restore
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			state_q <= IDC_RUN;
			idle_status_latch_q <= '0;
			stab_cnt_q <= '0;
		end else begin
			case (state_q)
				IDC_RUN: begin
					if (BUS.idle_instr) begin
						idle_status_latch_q <= icr_q; // RQ1
						state_q <= IDC_IDLE; // RQ4
					end
				end
				IDC_IDLE: begin
					if (wake_ev) begin
						stab_cnt_q <= '0;
						if (osc_off_q) begin
							state_q <= IDC_STAB; // RQ20
						end else begin
							idle_status_latch_q[`IDC_ICR_CLK] <= 1'b0; // RQ21
							idle_status_latch_q[`IDC_ICR_DEEP] <= 1'b0;
							state_q <= IDC_WAKE;
						end
					end
				end
				IDC_STAB: begin
					stab_cnt_q <= stab_cnt_q + 16'h0001; // RQ20
					if (stab_cnt_q == stab_last) begin
						idle_status_latch_q[`IDC_ICR_CLK] <= 1'b0; // RQ21
						idle_status_latch_q[`IDC_ICR_DEEP] <= 1'b0;
						state_q <= IDC_WAKE;
					end
				end
				IDC_WAKE: begin
					idle_status_latch_q <= '0; // RQ21
					state_q <= IDC_RUN;
				end
				default: begin
					state_q <= IDC_RUN;
				end
			endcase
		end
	end

	// Oscillator power-down on full deep idle, released by wake event
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			osc_off_q <= 1'b0;
		end else if (state_q == IDC_RUN && BUS.idle_instr) begin
			osc_off_q <= icr_q[`IDC_ICR_DEEP] & icr_q[`IDC_ICR_CLK] & pll_q[`IDC_PLL_OSCPD]; // RQ17
		end else if (idle_now && wake_ev) begin
			osc_off_q <= 1'b0; // RQ18
		end
	end

	// Sticky stops for modules that finish their activity first
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			dma_off_q <= 1'b0;
			peripheral_domain_idle_request_off_q <= '0;
			memory_interface_off_q <= 1'b0;
		end else if (state_q == IDC_WAKE || state_q == IDC_RUN) begin
			dma_off_q <= 1'b0;
			peripheral_domain_idle_request_off_q <= '0;
			memory_interface_off_q <= 1'b0;
		end else begin
			if (idle_status_latch_q[`IDC_ICR_MP] && master_port_idle_mask_q[`IDC_MASTER_PORT_IDLE_MASK_DMA] && !I_DMA_BUSY) begin
				dma_off_q <= 1'b1; // RQ5 RQ6
			end
			if (idle_status_latch_q[`IDC_ICR_PERIPHERAL_DOMAIN_IDLE_REQUEST]) begin
				peripheral_domain_idle_request_off_q <= peripheral_domain_idle_request_off_q | (peripheral_idle_mask_q & ~I_PERIPHERAL_DOMAIN_IDLE_REQUEST_BUSY); // RQ8 RQ9
			end
			if (memory_interface_req && !I_DMA_BUSY) begin
				memory_interface_off_q <= 1'b1; // RQ10
			end
		end
	end

	// Domain clock enables follow the latched status
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			O_CPU_CLK_EN <= 1'b1;
			O_DMA_CLK_EN <= 1'b1;
			O_HPI_CLK_EN <= 1'b1;
			O_ICACHE_CLK_EN <= 1'b1;
			O_IPORT_CLK_EN <= 1'b1;
			O_PERIPHERAL_DOMAIN_IDLE_REQUEST_CLK_EN <= '1;
			O_CLKGEN_CLK_EN <= 1'b1;
			O_MEMORY_INTERFACE_CLK_EN <= 1'b1;
			O_REFRESH_EN <= 1'b1;
			O_CPU_IDLE <= 1'b0;
		end else begin
			O_CPU_CLK_EN <= ~idle_status_latch_q[`IDC_ICR_CPU]; // RQ2 RQ3 RQ4
			O_DMA_CLK_EN <= ~dma_off_q; // RQ5
			O_HPI_CLK_EN <= ~(idle_status_latch_q[`IDC_ICR_MP] & master_port_idle_mask_q[`IDC_MASTER_PORT_IDLE_MASK_HPI]); // RQ5 RQ7
			O_ICACHE_CLK_EN <= ~idle_status_latch_q[`IDC_ICR_ICACHE]; // RQ2
			O_IPORT_CLK_EN <= ~idle_status_latch_q[`IDC_ICR_IPORT]; // RQ2
			O_PERIPHERAL_DOMAIN_IDLE_REQUEST_CLK_EN <= ~peripheral_domain_idle_request_off_q; // RQ8
			O_CLKGEN_CLK_EN <= ~idle_status_latch_q[`IDC_ICR_CLK]; // RQ13 RQ16
			O_MEMORY_INTERFACE_CLK_EN <= ~memory_interface_off_q; // RQ10
			O_REFRESH_EN <= ~memory_interface_off_q; // RQ11
			O_CPU_IDLE <= idle_status_latch_q[`IDC_ICR_CPU]; // RQ4
		end
	end

	// PLL core and oscillator power-down outputs
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			O_PLL_PWRDN <= 1'b0;
			O_OSC_PWRDN <= 1'b0;
		end else begin
			O_PLL_PWRDN <= (idle_now && idle_status_latch_q[`IDC_ICR_DEEP] && idle_status_latch_q[`IDC_ICR_CLK])
				| pll_q[`IDC_PLL_PWRDN]; // RQ16
			O_OSC_PWRDN <= osc_off_q & idle_now; // RQ17
		end
	end
endmodule

// >>> rtl/idc_if.sv
// Link between the software end and the idle controller
`timescale 1ns/100ps
interface idc_if;
	logic [2:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic wr;
	logic rd;
	logic idle_instr;

	modport dev (input addr, input wdata, input wr, input rd, input idle_instr, output rdata);
	modport sw (output addr, output wdata, output wr, output rd, output idle_instr, input rdata);
endinterface

// >>> rtl/idc_map.svh
// Offsets, field positions, reset values and counts of the idle domain clock controller
// Behaviour
// RQ1: Idle instruction copies control word into status
// RQ2: Status bits gate their own domain clocks
// RQ3: Six domains each get their own gate; code gates seven control-word domains (bits 0 to 6)
// RQ4: Bit 0 plus idle instruction idles CPU
// RQ5: DMA/host clocks stop: mask bit and status
// RQ6: DMA stops once current transfer ends
// RQ7: Host port stops at once; software checks
// RQ8: Peripheral clock stops: mask bit and status
// RQ9: Busy peripheral waits for activity to finish
// RQ10: Memory interface idles only after DMA idles
// RQ11: No SDRAM refresh while memory interface idle
// RQ12: Memory idle needs CPU, ports, cache, DMA idle
// RQ13: Partial deep idle keeps clock generator running
// RQ14: Deepest idle: bypass PLL, power down, reset
// RQ15: Deepest idle writes 3FFF, 0003, 03FF first
// RQ16: Full deep idle powers PLL down, stops all
// RQ17: Oscillator power-down with wake mask, bit 1
// RQ18: Wake only on selected, enabled events
// RQ19: Software avoids invalid domain combinations
// RQ20: Oscillator wake counts 41032 cycles then resumes
// RQ21: Wake restores clock generator before other domains
`ifndef IDC_MAP_SVH
`define IDC_MAP_SVH

// Device register indexes
`define IDC_IDX_ICR 3'h0
`define IDC_IDX_IDLE_STATUS_LATCH 3'h1
`define IDC_IDX_MASTER_PORT_IDLE_MASK 3'h2
`define IDC_IDX_PERIPHERAL_IDLE_MASK 3'h3
`define IDC_IDX_PLL 3'h4
`define IDC_IDX_OSCILLATOR_WAKE_MASK 3'h5
`define IDC_IDX_IER 3'h6
`define IDC_IDX_STAT 3'h7

// Idle control word fields
`define IDC_ICR_W 10
`define IDC_ICR_CPU 0
`define IDC_ICR_MP 1
`define IDC_ICR_ICACHE 2
`define IDC_ICR_PERIPHERAL_DOMAIN_IDLE_REQUEST 3
`define IDC_ICR_CLK 4
`define IDC_ICR_MEMORY_INTERFACE 5
`define IDC_ICR_IPORT 6
`define IDC_ICR_DEEP 9

// Master port mask fields
`define IDC_MASTER_PORT_IDLE_MASK_W 2
`define IDC_MASTER_PORT_IDLE_MASK_DMA 0
`define IDC_MASTER_PORT_IDLE_MASK_HPI 1

// Peripheral mask
`define IDC_PERIPHERAL_IDLE_MASK_W 14
`define IDC_PERIPHERAL_IDLE_MASK_MEMORY_INTERFACE 13

// PLL control fields
`define IDC_PLL_W 4
`define IDC_PLL_EN 0
`define IDC_PLL_PWRDN 1
`define IDC_PLL_RST 2
`define IDC_PLL_OSCPD 3
`define IDC_PLL_RESET 4'h1

// Wake mask and interrupt enable
`define IDC_OSCILLATOR_WAKE_MASK_W 5
`define IDC_OSCILLATOR_WAKE_MASK_NMI 0
`define IDC_OSCILLATOR_WAKE_MASK_EXTERNAL_INTERRUPT_ZERO 1
`define IDC_INT_W 4

// Deepest idle values
`define IDC_DEEP_PERIPHERAL_IDLE_MASK 14'h3FFF
`define IDC_DEEP_MASTER_PORT_IDLE_MASK 2'h3
`define IDC_DEEP_ICR 10'h3FF

// Oscillator stabilisation, reference clock cycles
`define IDC_OSC_STAB_CYC 41032

// Software end register offsets
`define IDC_SW_FWD_IDX 3'h0
`define IDC_SW_FWD_DATA 3'h1
`define IDC_SW_CMD 3'h2
`define IDC_SW_RESULT 3'h3
`define IDC_SW_STATUS 3'h4
`define IDC_SW_CMD_IDLE 0
`define IDC_SW_CMD_READ 1
`define IDC_SW_ST_REFUSED 0
`define IDC_SW_ST_PEND 1

`endif

// >>> rtl/idc_pkg.sv
// Types shared by both ends of the idle domain clock controller
package idc_pkg;
	typedef logic [15:0] idc_word_t;
	typedef logic [2:0] idc_idx_t;
	typedef enum logic [1:0] {
		IDC_RUN,
		IDC_IDLE,
		IDC_STAB,
		IDC_WAKE
	} idc_state_e;
endpackage

// >>> rtl/idc_sw.sv
// Software end: command registers, shadowed settings, checked idle instruction
`timescale 1ns/100ps
`include "idc_map.svh"
module idc_sw (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	// Plain register port
	input wire idc_pkg::idc_idx_t I_ADDR,
	input wire idc_pkg::idc_word_t I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output idc_pkg::idc_word_t O_RDATA,
	// Host port activity
	input wire logic I_HPI_BUSY,
	// Link to idle controller
	idc_if.sw BUS
);
	import idc_pkg::*;

	idc_idx_t fwd_idx_q;
	idc_word_t result_q;
	idc_word_t rdata_q;
	logic [`IDC_ICR_W-1:0] icr_sh_q;
	logic [`IDC_MASTER_PORT_IDLE_MASK_W-1:0] master_port_idle_mask_sh_q;
	logic [`IDC_PERIPHERAL_IDLE_MASK_W-1:0] peripheral_idle_mask_sh_q;
	logic [`IDC_PLL_W-1:0] pll_sh_q;
	logic refused_q;
	logic pend_q;
	logic cfg_ok;
	logic fwd_wr;
	logic cmd_wr;

	// Settings legal for the idle instruction
	function automatic logic cfg_valid(input logic [`IDC_ICR_W-1:0] idle_control_word,
		input logic [`IDC_MASTER_PORT_IDLE_MASK_W-1:0] master_port_idle_mask, input logic [`IDC_PERIPHERAL_IDLE_MASK_W-1:0] peripheral_idle_mask,
		input logic [`IDC_PLL_W-1:0] pll, input logic hpi_busy);
		logic ok;
		ok = 1'b1;
		if (idle_control_word[`IDC_ICR_CLK] && !idle_control_word[`IDC_ICR_CPU]) begin
			ok = 1'b0; // RQ19
		end
		if (idle_control_word[`IDC_ICR_MP] && master_port_idle_mask[`IDC_MASTER_PORT_IDLE_MASK_HPI] && hpi_busy) begin
			ok = 1'b0; // RQ7
		end
		if (idle_control_word[`IDC_ICR_MEMORY_INTERFACE] && (idle_control_word[6:0] != 7'h7F || master_port_idle_mask != `IDC_DEEP_MASTER_PORT_IDLE_MASK)) begin
			ok = 1'b0; // RQ12
		end
		if (idle_control_word[`IDC_ICR_DEEP] && (idle_control_word != `IDC_DEEP_ICR || master_port_idle_mask != `IDC_DEEP_MASTER_PORT_IDLE_MASK
			|| peripheral_idle_mask != `IDC_DEEP_PERIPHERAL_IDLE_MASK || pll[`IDC_PLL_EN]
			|| !pll[`IDC_PLL_PWRDN] || !pll[`IDC_PLL_RST])) begin
			ok = 1'b0; // RQ14 RQ15
		end
		return ok;
	endfunction

	assign cfg_ok = cfg_valid(icr_sh_q, master_port_idle_mask_sh_q, peripheral_idle_mask_sh_q, pll_sh_q, I_HPI_BUSY);
	assign fwd_wr = I_WR && (I_ADDR == `IDC_SW_FWD_DATA);
	assign cmd_wr = I_WR && (I_ADDR == `IDC_SW_CMD);

	// Forward index and shadows of what was sent
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			fwd_idx_q <= '0;
			icr_sh_q <= '0;
			master_port_idle_mask_sh_q <= '0;
			peripheral_idle_mask_sh_q <= '0;
			pll_sh_q <= `IDC_PLL_RESET;
		end else if (I_WR && I_ADDR == `IDC_SW_FWD_IDX) begin
			fwd_idx_q <= I_WDATA[2:0];
		end else if (fwd_wr) begin
			if (fwd_idx_q == `IDC_IDX_ICR) begin
				icr_sh_q <= I_WDATA[`IDC_ICR_W-1:0];
			end else if (fwd_idx_q == `IDC_IDX_MASTER_PORT_IDLE_MASK) begin
				master_port_idle_mask_sh_q <= I_WDATA[`IDC_MASTER_PORT_IDLE_MASK_W-1:0];
			end else if (fwd_idx_q == `IDC_IDX_PERIPHERAL_IDLE_MASK) begin
				peripheral_idle_mask_sh_q <= I_WDATA[`IDC_PERIPHERAL_IDLE_MASK_W-1:0];
			end else if (fwd_idx_q == `IDC_IDX_PLL) begin
				pll_sh_q <= I_WDATA[`IDC_PLL_W-1:0];
			end
		end
	end

	// Link strobes, one cycle each
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			BUS.addr <= '0;
			BUS.wdata <= '0;
			BUS.wr <= 1'b0;
			BUS.rd <= 1'b0;
			BUS.idle_instr <= 1'b0;
		end else begin
			BUS.wr <= fwd_wr;
			BUS.rd <= cmd_wr && I_WDATA[`IDC_SW_CMD_READ];
			BUS.idle_instr <= cmd_wr && I_WDATA[`IDC_SW_CMD_IDLE] && cfg_ok; // RQ4 RQ13 RQ17
			if (fwd_wr || cmd_wr) begin
				BUS.addr <= fwd_idx_q;
				BUS.wdata <= I_WDATA;
			end
		end
	end

	// Read completion and refusal flag; a new refusal wins over the clear
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			pend_q <= 1'b0;
			result_q <= '0;
			refused_q <= 1'b0;
		end else begin
			pend_q <= BUS.rd;
			if (pend_q) begin
				result_q <= BUS.rdata;
			end
			if (cmd_wr && I_WDATA[`IDC_SW_CMD_IDLE] && !cfg_ok) begin
				refused_q <= 1'b1; // RQ19
			end else if (I_WR && I_ADDR == `IDC_SW_STATUS && I_WDATA[`IDC_SW_ST_REFUSED]) begin
				refused_q <= 1'b0;
			end
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			rdata_q <= '0;
		end else if (I_RD) begin
			if (I_ADDR == `IDC_SW_FWD_IDX) begin
				rdata_q <= {13'h0000, fwd_idx_q};
			end else if (I_ADDR == `IDC_SW_RESULT) begin
				rdata_q <= result_q;
			end else if (I_ADDR == `IDC_SW_STATUS) begin
				rdata_q <= {14'h0000, BUS.rd | pend_q, refused_q};
			end else begin
				rdata_q <= '0;
			end
		end else begin
			rdata_q <= '0;
		end
	end
	assign O_RDATA = rdata_q;
endmodule

// >>> tb/idc_props.sv
// Checker for the link and the domain enables of the idle controller
`timescale 1ns/100ps
module idc_props (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	// Link signals
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic idle_instr,
	// Controller pins
	input wire logic I_DMA_BUSY,
	input wire logic O_CPU_IDLE,
	input wire logic O_CPU_CLK_EN,
	input wire logic O_DMA_CLK_EN,
	input wire logic O_CLKGEN_CLK_EN,
	input wire logic O_MEMORY_INTERFACE_CLK_EN,
	input wire logic O_REFRESH_EN,
	input wire logic O_PLL_PWRDN
);
	logic [9:0] icr_q;
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SRST);
	// Shadow of the idle control word written over the link
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			icr_q <= 10'h000;
		end else if (wr && addr == 3'h0) begin
			icr_q <= wdata[9:0];
		end
	end
	property p_no_dual; !(wr && rd); endproperty
	a_no_dual: assert property (p_no_dual) else $error("Link read and write together");
	property p_rdata_zero; !$past(rd) |-> rdata == 16'h0000; endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("Read data outside its cycle");
	property p_cpu_idle; idle_instr && icr_q[0] && !O_CPU_IDLE |-> ##[1:3] O_CPU_IDLE; endproperty
	a_cpu_idle: assert property (p_cpu_idle) else $error("CPU not idled");
	property p_clkgen_kept; idle_instr && !icr_q[4] |-> O_CLKGEN_CLK_EN [*6]; endproperty
	a_clkgen_kept: assert property (p_clkgen_kept) else $error("Clock generator gated");
	property p_pll_deep;
		idle_instr && icr_q[9] && icr_q[4] |-> ##[1:4] (O_PLL_PWRDN && !O_CLKGEN_CLK_EN);
	endproperty
	a_pll_deep: assert property (p_pll_deep) else $error("Full deep idle not reached");
	property p_refresh; O_REFRESH_EN == O_MEMORY_INTERFACE_CLK_EN; endproperty
	a_refresh: assert property (p_refresh) else $error("Refresh while memory idle");
	property p_memory_interface_dma;
		$fell(O_MEMORY_INTERFACE_CLK_EN) |-> !($past(I_DMA_BUSY) && $past(I_DMA_BUSY, 2) && $past(I_DMA_BUSY, 3));
	endproperty
	a_memory_interface_dma: assert property (p_memory_interface_dma) else $error("Memory idled during DMA");
	property p_dma_busy;
		$fell(O_DMA_CLK_EN) |-> !($past(I_DMA_BUSY) && $past(I_DMA_BUSY, 2) && $past(I_DMA_BUSY, 3));
	endproperty
	a_dma_busy: assert property (p_dma_busy) else $error("DMA stopped mid transfer");
	property p_clkgen_first; $rose(O_CPU_CLK_EN) |-> $past(O_CLKGEN_CLK_EN); endproperty
	a_clkgen_first: assert property (p_clkgen_first) else $error("CPU woke before clock gen");
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for both ends of the idle controller
`timescale 1ns/100ps
module tb_top;
	import idc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	idc_idx_t adr = 3'h0;
	idc_word_t wd = 16'h0000;
	logic we = 1'b0;
	logic re = 1'b0;
	idc_word_t rdo;
	logic hbusy = 1'b0;
	logic dbusy = 1'b0;
	logic [13:0] pbusy = 14'h0000;
	logic nmi = 1'b0;
	logic [3:0] xint = 4'h0;
	logic cpu_en, dma_en, hpi_en, ic_en, ip_en, cg_en, memory_interface_en, refr, pllpd, oscpd, cpu_idle;
	logic [13:0] peripheral_domain_idle_request_en;
	int error_cnt = 0;
	int cmp_count = 0;
	idc_word_t v;
	idc_word_t bad [3] = '{16'h0010, 16'h0020, 16'h03FF};
	idc_if lnk ();
	// Clock source
	always #10 clk = ~clk;
	// Both ends joined by the link
	idc_sw idc_sw_i (.I_SYS_CLK(clk), .I_SRST(rst), .I_ADDR(adr), .I_WDATA(wd), .I_WR(we),
		.I_RD(re), .O_RDATA(rdo), .I_HPI_BUSY(hbusy), .BUS(lnk));
	idc_ctrl #(.OSC_STAB_CYC(20)) idc_ctrl_i (.I_SYS_CLK(clk), .I_SRST(rst), .BUS(lnk),
		.I_DMA_BUSY(dbusy), .I_PERIPHERAL_DOMAIN_IDLE_REQUEST_BUSY(pbusy), .I_NMI(nmi), .I_EXT_INT(xint),
		.O_CPU_CLK_EN(cpu_en), .O_DMA_CLK_EN(dma_en), .O_HPI_CLK_EN(hpi_en),
		.O_ICACHE_CLK_EN(ic_en), .O_IPORT_CLK_EN(ip_en), .O_PERIPHERAL_DOMAIN_IDLE_REQUEST_CLK_EN(peripheral_domain_idle_request_en),
		.O_CLKGEN_CLK_EN(cg_en), .O_MEMORY_INTERFACE_CLK_EN(memory_interface_en), .O_REFRESH_EN(refr),
		.O_PLL_PWRDN(pllpd), .O_OSC_PWRDN(oscpd), .O_CPU_IDLE(cpu_idle));
	idc_props idc_props_i (.I_SYS_CLK(clk), .I_SRST(rst), .addr(lnk.addr), .wdata(lnk.wdata),
		.rdata(lnk.rdata), .wr(lnk.wr), .rd(lnk.rd), .idle_instr(lnk.idle_instr),
		.I_DMA_BUSY(dbusy), .O_CPU_IDLE(cpu_idle), .O_CPU_CLK_EN(cpu_en),
		.O_DMA_CLK_EN(dma_en), .O_CLKGEN_CLK_EN(cg_en), .O_MEMORY_INTERFACE_CLK_EN(memory_interface_en),
		.O_REFRESH_EN(refr), .O_PLL_PWRDN(pllpd));
	// Compare and count
	task automatic chk(input idc_word_t got, input idc_word_t exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Wait cycles, then step past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One write (w=1) or read (w=0) on the software port; read data lands in v
	task automatic bus(input idc_idx_t a, input idc_word_t d, input logic w);
		@(posedge clk);
		adr <= a;
		wd <= d;
		we <= w;
		re <= !w;
		@(posedge clk);
		we <= 1'b0;
		re <= 1'b0;
		#1;
		v = rdo;
	endtask
	// Forwarded device write and device read
	task automatic dw(input idc_idx_t i, input idc_word_t d);
		bus(3'h0, {13'h0, i}, 1'b1);
		bus(3'h1, d, 1'b1);
	endtask
	task automatic dr(input idc_idx_t i);
		bus(3'h0, {13'h0, i}, 1'b1);
		bus(3'h2, 16'h0002, 1'b1);
		cyc(4);
		bus(3'h3, 16'h0000, 1'b0);
	endtask
	// Idle instruction and wake pulse
	task automatic idle;
		bus(3'h2, 16'h0001, 1'b1);
		cyc(6);
	endtask
	task automatic wake(input logic n, input logic [3:0] x);
		nmi <= n;
		xint <= x;
		cyc(4);
		nmi <= 1'b0;
		xint <= 4'h0;
	endtask
	// Read the refusal flag, then clear it
	task automatic refused;
		bus(3'h4, 16'h0000, 1'b0);
		chk(v[0], 1'b1);
		bus(3'h4, 16'h0001, 1'b1);
	endtask
	task automatic t_reset;
		chk({cpu_en, dma_en, hpi_en, ic_en, ip_en, cg_en, memory_interface_en, refr}, 8'hFF);
		chk(peripheral_domain_idle_request_en, 14'h3FFF);
		chk({pllpd, oscpd, cpu_idle}, 3'h0);
		dr(3'h1);
		chk(v, 16'h0000);
	endtask
	task automatic t_cpu;
		dw(3'h5, 16'h0001);
		dw(3'h0, 16'h0001);
		idle;
		chk({cpu_idle, cpu_en}, 2'h2);
		chk({dma_en, hpi_en, cg_en, memory_interface_en}, 4'hF);
		dr(3'h1);
		chk(v, 16'h0001);
		wake(1'b1, 4'h0);
		cyc(6);
		chk({cpu_idle, cpu_en}, 2'h1);
	endtask
	task automatic t_refuse;
		foreach (bad[i]) begin
			dw(3'h0, bad[i]);
			bus(3'h2, 16'h0001, 1'b1);
			cyc(2);
			chk({cpu_idle, cg_en}, 2'h1);
			refused;
		end
	endtask
	task automatic t_mp;
		dw(3'h2, 16'h0003);
		dw(3'h5, 16'h0002);
		dw(3'h6, 16'h0001);
		dw(3'h0, 16'h0002);
		hbusy <= 1'b1;
		bus(3'h2, 16'h0001, 1'b1);
		refused;
		hbusy <= 1'b0;
		dbusy <= 1'b1;
		idle;
		chk({hpi_en, dma_en}, 2'h1);
		dbusy <= 1'b0;
		cyc(4);
		chk(dma_en, 1'b0);
		wake(1'b0, 4'h2);
		cyc(4);
		chk(hpi_en, 1'b0);
		wake(1'b0, 4'h1);
		cyc(6);
		chk({hpi_en, dma_en}, 2'h3);
	endtask
	task automatic t_peripheral_domain_idle_request;
		dw(3'h3, 16'h2005);
		dw(3'h0, 16'h0008);
		pbusy <= 14'h0004;
		dbusy <= 1'b1;
		idle;
		chk({peripheral_domain_idle_request_en[2:0], memory_interface_en, refr}, 5'h1B);
		pbusy <= 14'h0000;
		dbusy <= 1'b0;
		cyc(4);
		chk({peripheral_domain_idle_request_en[2:0], memory_interface_en, refr}, 5'h08);
		wake(1'b0, 4'h1);
		cyc(6);
		chk(peripheral_domain_idle_request_en, 14'h3FFF);
	endtask
	task automatic t_deep;
		dw(3'h4, 16'h000E);
		dw(3'h3, 16'h3FFF);
		dw(3'h0, 16'h03FF);
		idle;
		chk({cpu_en, dma_en, hpi_en, ic_en, ip_en, cg_en, memory_interface_en, refr}, 8'h00);
		chk({peripheral_domain_idle_request_en, pllpd, oscpd}, 16'h0003);
		wake(1'b0, 4'h1);
		cyc(12);
		chk(cpu_en, 1'b0);
		cyc(20);
		chk({cg_en, cpu_en}, 2'h3);
	endtask
	// Verdict and end of run
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		t_reset;
		t_cpu;
		t_refuse;
		t_mp;
		t_peripheral_domain_idle_request;
		t_deep;
		test_done;
	end
	// Watchdog against a hang
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		test_done;
	end
endmodule
